// ### design/mcu_port_pin_logic.sv
`timescale 1ns/10ps
`include "port_pin_params.svh"
module mcu_port_pin_logic
  import port_pin_pkg::*;
(
  input  wire logic         ref_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         rst_pin_i,
  // core side
  input  wire logic [7:0]   p0_latch_i,
  input  wire logic [7:0]   p1_latch_i,
  input  wire logic [7:0]   high_port_latch_i,
  input  wire logic [7:0]   p3_latch_i,
  input  wire logic [1:0]   bus_mode_i,
  input  wire logic         bus_addr_phase_i,
  input  wire logic [15:0]  bus_addr_i,
  input  wire logic         bus_data_out_en_i,
  input  wire logic [7:0]   bus_data_out_i,
  input  wire logic         ext_data_access_i,
  input  wire logic         prog_mode_i,
  input  wire logic         prog_verify_i,
  input  wire logic [7:0]   prog_code_out_i,
  input  wire logic         lock2_i,
  input  wire logic         t2_clk_out_en_i,
  input  wire logic         t2_clk_out_i,
  input  wire logic         spi_en_i,
  input  wire logic         spi_master_i,
  input  wire logic         spi_mosi_out_i,
  input  wire logic         spi_miso_out_i,
  input  wire logic         spi_sck_out_i,
  input  wire logic         txd_i,
  input  wire logic         wr_strobe_n_i,
  input  wire logic         rd_strobe_n_i,
  output logic [7:0]        p0_read_o,
  output logic [7:0]        p1_read_o,
  output logic [7:0]        p2_read_o,
  output logic [7:0]        p3_read_o,
  output logic [7:0]        bus_data_in_o,
  output logic [7:0]        prog_code_in_o,
  output logic [7:0]        prog_addr_lo_o,
  output logic [7:0]        prog_addr_hi_o,
  output logic              timer2_count_in_o,
  output logic              timer2_trigger_in_o,
  output logic              spi_ss_n_o,
  output logic              spi_mosi_in_o,
  output logic              spi_miso_in_o,
  output logic              spi_sck_in_o,
  output logic              isp_active_o,
  output logic              rxd_o,
  output logic              ext_irq_zero_in_o,
  output logic              ext_irq_one_in_o,
  output logic              timer_zero_ext_in_o,
  output logic              timer_one_ext_in_o,
  output logic              core_rst_o,
  output logic              ale_o,
  // pins
  input  wire logic [7:0]   p0_pin_i,
  output logic [7:0]        p0_pin_o,
  output logic [7:0]        p0_pin_oe_n_o,
  input  wire logic [7:0]   p1_pin_i,
  output logic [7:0]        p1_pin_o,
  output logic [7:0]        p1_pin_oe_n_o,
  input  wire logic [7:0]   p2_pin_i,
  output logic [7:0]        p2_pin_o,
  output logic [7:0]        p2_pin_oe_n_o,
  input  wire logic [7:0]   p3_pin_i,
  output logic [7:0]        p3_pin_o,
  output logic [7:0]        p3_pin_oe_n_o
);
  bus_mode_e mode;
  byte_t     p0_rd, p1_rd, p2_rd, p3_rd;
  byte_t     p0_val, p0_frc, p0_fv;
  byte_t     p1_val, p1_frc, p1_fv;
  byte_t     p2_frc, p2_fv;
  byte_t     p3_val;
  logic      in_reset;
  logic      isp;
  logic      ext_bus;
  logic      wide_pointer_ext_access;
  logic      short_pointer_ext_access;
  logic      p0_drive_bus;
  logic      spi_out_role;

  assign mode = bus_mode_e'(bus_mode_i);
  assign wide_pointer_ext_access  = (mode == BUS_WIDE);
  assign short_pointer_ext_access = (mode == BUS_SHORT);
  assign ext_bus = (mode != BUS_IDLE) && !prog_mode_i;

  // port 0: open drain latch; bus and verify drive both levels
  assign p0_drive_bus = ext_bus && (bus_addr_phase_i || bus_data_out_en_i); // [R02]
  assign p0_frc = {8{p0_drive_bus || (prog_mode_i && prog_verify_i)}};  // [R03]
  assign p0_fv  = prog_mode_i ? prog_code_out_i                          // [R03]
                : (bus_addr_phase_i ? bus_addr_i[7:0] : bus_data_out_i); // [R02]
  // code bytes in programming mode release the port so the programmer can drive
  assign p0_val = (prog_mode_i || ext_bus) ? `LATCH_RST : p0_latch_i;    // [R01]

  // port 1 alternates are ANDed with the latch so a zero latch wins, except MISO during serial programming
  assign isp          = in_reset && !lock2_i; // [R13]
  assign spi_out_role = spi_en_i && !isp;
  always_comb
  begin
    p1_val = p1_latch_i;                                                   // [R04]
    if (t2_clk_out_en_i)
      p1_val[`BIT_T2] = p1_latch_i[`BIT_T2] & t2_clk_out_i;               // [R05] [R15]
    if (spi_out_role && spi_master_i)
    begin
      p1_val[`BIT_MOSI] = p1_latch_i[`BIT_MOSI] & spi_mosi_out_i;         // [R06] [R15]
      p1_val[`BIT_SCK]  = p1_latch_i[`BIT_SCK] & spi_sck_out_i;           // [R06] [R15]
    end
    if (spi_out_role && !spi_master_i)
      p1_val[`BIT_MISO] = p1_latch_i[`BIT_MISO] & spi_miso_out_i;         // [R06] [R15]
    if (isp)
      p1_val[`BIT_MISO] = spi_miso_out_i;                                  // [R13]
    if (prog_mode_i)
      p1_val = `LATCH_RST;                                                 // [R07]
  end
  assign p1_frc = 8'h00;
  assign p1_fv  = 8'h00;

  // port 2: address byte forced only for fetches and wide pointer accesses
  assign p2_frc = {8{ext_bus && (wide_pointer_ext_access || mode == BUS_FETCH)}}; // [R08]
  assign p2_fv  = short_pointer_ext_access ? high_port_latch_i : bus_addr_i[15:8]; // [R09]

  // port 3 strobes and transmit gated by latch
  always_comb
  begin
    p3_val = p3_latch_i;                                                   // [R04]
    p3_val[`BIT_TXD] = p3_latch_i[`BIT_TXD] & txd_i;                      // [R11] [R15]
    p3_val[`BIT_WR]  = p3_latch_i[`BIT_WR] & wr_strobe_n_i;               // [R11] [R15]
    p3_val[`BIT_RD]  = p3_latch_i[`BIT_RD] & rd_strobe_n_i;               // [R11] [R15]
    if (prog_mode_i)
      p3_val = `LATCH_RST;                                                 // [R10]
  end

  pin_cell #(.W(`PORT_W)) u_p0 (
    .value_i(p0_val), .force_i(p0_frc), .force_val_i(p0_fv),
    .pin_i(p0_pin_i), .pin_o(p0_pin_o), .pin_oe_n_o(p0_pin_oe_n_o), .read_o(p0_rd)
  );
  pin_cell #(.W(`PORT_W)) u_p1 (
    .value_i(p1_val), .force_i(p1_frc), .force_val_i(p1_fv),
    .pin_i(p1_pin_i), .pin_o(p1_pin_o), .pin_oe_n_o(p1_pin_oe_n_o), .read_o(p1_rd)
  );
  // p2 quasi value is its latch whenever the address is not forced and programming is off
  pin_cell #(.W(`PORT_W)) u_p2 (
    .value_i(prog_mode_i ? `LATCH_RST : high_port_latch_i), .force_i(p2_frc), .force_val_i(p2_fv),
    .pin_i(p2_pin_i), .pin_o(p2_pin_o), .pin_oe_n_o(p2_pin_oe_n_o), .read_o(p2_rd)
  );
  pin_cell #(.W(`PORT_W)) u_p3 (
    .value_i(p3_val), .force_i(8'h00), .force_val_i(8'h00),
    .pin_i(p3_pin_i), .pin_o(p3_pin_o), .pin_oe_n_o(p3_pin_oe_n_o), .read_o(p3_rd)
  );

  // reset pin qualification
  reset_filter #(.CYC(`RST_MC * `OSC_PER_MC)) u_rst (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .rst_pin_i(rst_pin_i), .core_rst_o(in_reset)
  );
  assign core_rst_o   = in_reset;
  assign isp_active_o = isp;

  // input routing, registered so data outputs come from flip-flops
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      p0_read_o <= `LATCH_RST;
      p1_read_o <= `LATCH_RST;
      p2_read_o <= `LATCH_RST;
      p3_read_o <= `LATCH_RST;
    end
    else
    begin
      p0_read_o <= p0_rd; // [R01]
      p1_read_o <= p1_rd; // [R04]
      p2_read_o <= p2_rd; // [R04]
      p3_read_o <= p3_rd; // [R04]
    end
  assign bus_data_in_o  = p0_read_o;                       // [R02]
  assign prog_code_in_o = p0_read_o;                       // [R03]
  assign prog_addr_lo_o = p1_read_o;                       // [R07]
  assign prog_addr_hi_o = p2_read_o;                       // [R10]
  assign timer2_count_in_o   = p1_read_o[`BIT_T2];         // [R05]
  assign timer2_trigger_in_o = p1_read_o[`BIT_TIMER2_TRIGGER_IN];       // [R05]
  assign spi_ss_n_o     = p1_read_o[`BIT_SS];              // [R06]
  assign spi_mosi_in_o  = p1_read_o[`BIT_MOSI];            // [R06] [R13]
  assign spi_miso_in_o  = p1_read_o[`BIT_MISO];            // [R06]
  assign spi_sck_in_o   = p1_read_o[`BIT_SCK];             // [R06] [R13]
  assign rxd_o               = p3_read_o[`BIT_RXD];        // [R11]
  assign ext_irq_zero_in_o   = p3_read_o[`BIT_EXT_IRQ_ZERO_IN];       // [R11]
  assign ext_irq_one_in_o    = p3_read_o[`BIT_EXT_IRQ_ONE_IN];       // [R11]
  assign timer_zero_ext_in_o = p3_read_o[`BIT_T0];         // [R11]
  assign timer_one_ext_in_o  = p3_read_o[`BIT_T1];         // [R11]

  // address latch pulse: one clock high every six; a data access swallows one
  logic [2:0] ale_cnt_q;
  logic       ale_q;
  logic       skip_q;
  wire        ale_wrap = (ale_cnt_q == 3'(`ALE_DIV - 1));
  wire        skip_d   = ale_wrap ? 1'b0 : (skip_q | ext_data_access_i);
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      ale_cnt_q <= 3'h0;
      ale_q     <= 1'b0;
      skip_q    <= 1'b0;
    end
    else
    begin
      ale_cnt_q <= ale_wrap ? 3'h0 : ale_cnt_q + 3'h1;
      ale_q     <= ale_wrap && !(skip_q | ext_data_access_i) && !in_reset && !prog_mode_i; // [R14]
      skip_q    <= skip_d;
    end
  assign ale_o = ale_q;
endmodule : mcu_port_pin_logic

// ### design/pin_cell.sv
`timescale 1ns/10ps
`include "port_pin_params.svh"
// one quasi-bidirectional pin group: unforced bits drive low when output is zero, else release
module pin_cell #(
  parameter int W = `PORT_W
) (
  input  wire logic [W-1:0] value_i,
  input  wire logic [W-1:0] force_i,
  input  wire logic [W-1:0] force_val_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] pin_o,
  output logic      [W-1:0] pin_oe_n_o,
  output logic      [W-1:0] read_o
);
  // forced bits drive both levels; others are quasi, only a zero is driven
  assign pin_o      = force_i & force_val_i | ~force_i & value_i;
  assign pin_oe_n_o = ~(force_i | ~value_i);
  assign read_o     = pin_i;
endmodule : pin_cell

// ### design/port_pin_params.svh
`ifndef PORT_PIN_PARAMS_SVH
`define PORT_PIN_PARAMS_SVH
// Overview of operation
// [R01] first port: eight open-drain pins; latch one releases pin for input
// [R02] external memory cycles: first port carries multiplexed low address and data, pulled up
// [R03] programming: first port takes code bytes; verify drives them, programmer pulls up
// [R04] second to fourth ports: bidirectional with pullups; latch one lets pin read back
// [R05] second port bits 0,1: third timer count in or clock out, and trigger in
// [R06] second port bits 4-7: SPI select, MOSI, MISO, SCK directions follow master role
// [R07] programming: low address byte accepted on second port
// [R08] third port drives high address on fetches and wide pointer data accesses, strong ones
// [R09] short pointer data accesses: third port keeps driving its own latch
// [R10] programming: high address and controls accepted on third port
// [R11] fourth port bits: receive, transmit, two interrupts, two timer inputs, write, read strobes
// [R12] reset pin high two machine cycles with clock running resets device
// [R13] reset held: SPI pins become serial programming port unless lock level two set
// [R14] address latch pulse every six clocks; one skipped per external data access
// [R15] alternate outputs reach pin only while latch bit is one; MISO during serial programming is driven regardless of latch
`define PORT_W          8
`define LATCH_RST       8'hff
`define OSC_PER_MC      12
`define RST_MC          2
`define ALE_DIV         6
`define BIT_T2          0
`define BIT_TIMER2_TRIGGER_IN        1
`define BIT_SS          4
`define BIT_MOSI        5
`define BIT_MISO        6
`define BIT_SCK         7
`define BIT_RXD         0
`define BIT_TXD         1
`define BIT_EXT_IRQ_ZERO_IN        2
`define BIT_EXT_IRQ_ONE_IN        3
`define BIT_T0          4
`define BIT_T1          5
`define BIT_WR          6
`define BIT_RD          7
`endif

// ### design/port_pin_pkg.sv
package port_pin_pkg;
  typedef enum logic [1:0] {BUS_IDLE, BUS_WIDE, BUS_SHORT, BUS_FETCH} bus_mode_e;
  typedef logic [7:0] byte_t;
endpackage : port_pin_pkg

// ### design/reset_filter.sv
`timescale 1ns/10ps
`include "port_pin_params.svh"
// reset pin must stay high this many clocks before reset is declared
module reset_filter #(
  parameter int CYC = `RST_MC * `OSC_PER_MC
) (
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  input  wire logic rst_pin_i,
  output logic      core_rst_o
);
  logic [7:0] cnt_q;
  logic       rst_q;
  wire        full = (cnt_q == 8'(CYC - 1));
  // short glitches restart the count, so noise never resets the core
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      cnt_q <= 8'h00;
      rst_q <= 1'b0;
    end
    else
    begin
      cnt_q <= !rst_pin_i ? 8'h00 : (full ? cnt_q : cnt_q + 8'h01);
      rst_q <= rst_pin_i && full; // [R12]
    end
  assign core_rst_o = rst_q;
endmodule : reset_filter

// ### test/pin_side_model.sv
`timescale 1ns/10ps
// far side of one port: memory or programmer pulls lines where it drives, pullups elsewhere
module pin_side_model (
  input  wire logic [7:0] pin_o,
  input  wire logic [7:0] oe_n,
  input  wire logic [7:0] drv_en,
  input  wire logic [7:0] drv_val,
  output logic      [7:0] level
);
  // wired-and; a released line rises on the pullup instead of keeping a stale value
  assign level = (oe_n | pin_o) & (~drv_en | drv_val);
endmodule : pin_side_model

// ### test/port_pin_checker.sv
`timescale 1ns/10ps
module port_pin_checker (
  input wire logic        ref_clk_i, rst_n_i, rst_pin_i, lock2_i, core_rst_o, isp_active_o, ale_o,
  input wire logic        prog_mode_i, prog_verify_i, bus_addr_phase_i, ext_data_access_i,
  input wire logic [1:0]  bus_mode_i,
  input wire logic [15:0] bus_addr_i,
  input wire logic [7:0]  p3_latch_i, prog_code_out_i, p1_pin_i, p2_pin_i, prog_addr_lo_o, prog_addr_hi_o,
  input wire logic [7:0]  p0_pin_o, p0_pin_oe_n_o, p2_pin_o, p2_pin_oe_n_o, p3_pin_o, p3_pin_oe_n_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [4:0] hi_cnt_q;
  // consecutive high samples of the reset pin; saturates so a long hold never wraps
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
    if (!rst_n_i) hi_cnt_q <= 5'h00;
    else if (!rst_pin_i) hi_cnt_q <= 5'h00;
    else if (hi_cnt_q != 5'h1f) hi_cnt_q <= hi_cnt_q + 5'h01;
  rst_rise_a: assert property ($rose(core_rst_o) |-> hi_cnt_q == 5'h18) else $error("early core reset");
  rst_fall_a: assert property (!rst_pin_i [*3] |-> !core_rst_o) else $error("core reset stuck");
  isp_gate_a: assert property (isp_active_o == (core_rst_o && !lock2_i)) else $error("isp gating");
  prog_addr_a: assert property (1 |=> {prog_addr_hi_o, prog_addr_lo_o} == $past({p2_pin_i, p1_pin_i}))
    else $error("prog address");
  wide_addr_a: assert property (bus_mode_i[0] && !prog_mode_i && !core_rst_o |->
    p2_pin_oe_n_o == 8'h00 && p2_pin_o == bus_addr_i[15:8]) else $error("high address");
  low_addr_a: assert property (bus_mode_i != 2'h0 && bus_addr_phase_i && !prog_mode_i && !core_rst_o |->
    p0_pin_oe_n_o == 8'h00 && p0_pin_o == bus_addr_i[7:0]) else $error("low address");
  verify_out_a: assert property (prog_mode_i && prog_verify_i |-> (p0_pin_oe_n_o | p0_pin_o) == prog_code_out_i)
    else $error("verify data");
  latch_low_a: assert property (!prog_mode_i && !core_rst_o |-> ((p3_pin_oe_n_o | p3_pin_o) & ~p3_latch_i) == 8'h00)
    else $error("latch zero not low");
  ale_rate_a: assert property (ale_o ##0 (!ext_data_access_i && !prog_mode_i && !core_rst_o) [*6] |=> ale_o)
    else $error("address latch rate");
  ale_skip_a: assert property (ale_o ##1 ext_data_access_i |-> ##5 !ale_o) else $error("latch pulse not skipped");
  cover property ($rose(core_rst_o));
  cover property (ale_o ##1 ext_data_access_i);
  cover property (prog_mode_i && prog_verify_i);
endmodule : port_pin_checker
bind mcu_port_pin_logic port_pin_checker checker_inst (.*);

// ### test/test_mcu_port_pin_logic.sv
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_mcu_port_pin_logic;
  import port_pin_pkg::*;
  logic ref_clk_i, rst_n_i, rst_pin_i, bus_addr_phase_i, bus_data_out_en_i, ext_data_access_i, prog_mode_i;
  logic prog_verify_i, lock2_i, t2_clk_out_en_i, t2_clk_out_i, spi_en_i, spi_master_i, spi_mosi_out_i;
  logic spi_miso_out_i, spi_sck_out_i, txd_i, wr_strobe_n_i, rd_strobe_n_i, timer2_count_in_o, timer2_trigger_in_o;
  logic spi_ss_n_o, spi_mosi_in_o, spi_miso_in_o, spi_sck_in_o, isp_active_o, rxd_o, ext_irq_zero_in_o;
  logic ext_irq_one_in_o, timer_zero_ext_in_o, timer_one_ext_in_o, core_rst_o, ale_o;
  logic [1:0]      bus_mode_i;
  logic [15:0]     bus_addr_i;
  logic [3:0][7:0] drv_en, drv_val;
  byte_t p0_latch_i, p1_latch_i, high_port_latch_i, p3_latch_i, bus_data_out_i, prog_code_out_i, e1, e3;
  byte_t p0_read_o, p1_read_o, p2_read_o, p3_read_o, bus_data_in_o, prog_code_in_o, prog_addr_lo_o, prog_addr_hi_o;
  byte_t p0_pin_i, p0_pin_o, p0_pin_oe_n_o, p1_pin_i, p1_pin_o, p1_pin_oe_n_o;
  byte_t p2_pin_i, p2_pin_o, p2_pin_oe_n_o, p3_pin_i, p3_pin_o, p3_pin_oe_n_o;
  int    mismatches, tests_run, cnt;
  mcu_port_pin_logic DUT (.*);
  pin_side_model m0 (.pin_o(p0_pin_o), .oe_n(p0_pin_oe_n_o), .drv_en(drv_en[0]), .drv_val(drv_val[0]), .level(p0_pin_i));
  pin_side_model m1 (.pin_o(p1_pin_o), .oe_n(p1_pin_oe_n_o), .drv_en(drv_en[1]), .drv_val(drv_val[1]), .level(p1_pin_i));
  pin_side_model m2 (.pin_o(p2_pin_o), .oe_n(p2_pin_oe_n_o), .drv_en(drv_en[2]), .drv_val(drv_val[2]), .level(p2_pin_i));
  pin_side_model m3 (.pin_o(p3_pin_o), .oe_n(p3_pin_oe_n_o), .drv_en(drv_en[3]), .drv_val(drv_val[3]), .level(p3_pin_i));
  initial
  begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  // expected quasi pin: latch, alternate output and far side each can only pull low
  function automatic byte_t lvl(byte_t latch, byte_t alt, byte_t en, byte_t val);
    return latch & alt & (~en | val);
  endfunction : lvl
  task automatic tick(int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : tick
  task automatic give_verdict();
    $display("compared %0d, mismatched %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  initial
  begin
    {rst_pin_i, bus_addr_phase_i, bus_data_out_en_i, ext_data_access_i, prog_mode_i, prog_verify_i, lock2_i} = '0;
    {t2_clk_out_en_i, t2_clk_out_i, spi_en_i, spi_mosi_out_i, spi_miso_out_i, spi_sck_out_i, bus_mode_i} = '0;
    {spi_master_i, txd_i, wr_strobe_n_i, rd_strobe_n_i} = 4'hf;
    {p0_latch_i, p1_latch_i, high_port_latch_i, p3_latch_i} = 32'hffff_ffff;
    {bus_addr_i, bus_data_out_i, prog_code_out_i, drv_en, drv_val} = '0;
    rst_n_i = 1'b0;
    void'($urandom(22884));
    tick(6);
    rst_n_i = 1'b1;
    // random latches, alternate outputs and far-side pulls with the bus idle
    repeat (40)
    begin
      @(posedge ref_clk_i);
      {p0_latch_i, p1_latch_i, p3_latch_i, high_port_latch_i} <= $urandom();
      {txd_i, wr_strobe_n_i, rd_strobe_n_i, t2_clk_out_en_i, t2_clk_out_i, spi_en_i, spi_mosi_out_i, spi_sck_out_i,
        spi_master_i, spi_miso_out_i} <= 10'($urandom());
      drv_en <= $urandom();
      drv_val <= $urandom();
      tick(1);
      e1 = lvl(p1_latch_i, {spi_sck_out_i | ~(spi_en_i & spi_master_i), spi_miso_out_i | ~(spi_en_i & ~spi_master_i),
        spi_mosi_out_i | ~(spi_en_i & spi_master_i), 4'hf, t2_clk_out_i | ~t2_clk_out_en_i}, drv_en[1], drv_val[1]);
      e3 = lvl(p3_latch_i, {rd_strobe_n_i, wr_strobe_n_i, 4'hf, txd_i, 1'h1}, drv_en[3], drv_val[3]);
      `CHK(p0_read_o, lvl(p0_latch_i, 8'hff, drv_en[0], drv_val[0]))
      `CHK({p2_read_o, p1_read_o, p3_read_o}, {lvl(high_port_latch_i, 8'hff, drv_en[2], drv_val[2]), e1, e3})
      `CHK({timer2_trigger_in_o, timer2_count_in_o}, e1[1:0])
      `CHK({spi_sck_in_o, spi_miso_in_o, spi_mosi_in_o, spi_ss_n_o}, e1[7:4])
      `CHK({timer_one_ext_in_o, timer_zero_ext_in_o, ext_irq_one_in_o, ext_irq_zero_in_o, rxd_o}, {e3[5:2], e3[0]})
    end
    $display("quasi port test done");
    // every external bus mode: address phase, write data, then read data
    for (int m = 1; m < 4; m++)
    begin
      @(posedge ref_clk_i);
      {bus_mode_i, bus_addr_phase_i, p0_latch_i, drv_en} <= {m[1:0], 1'b1, 8'hff, 32'h0000_0000};
      bus_addr_i <= 16'($urandom());
      high_port_latch_i <= $urandom();
      tick(1);
      `CHK({p2_read_o, p0_read_o}, {m == 2 ? high_port_latch_i : bus_addr_i[15:8], bus_addr_i[7:0]})
      @(posedge ref_clk_i);
      {bus_addr_phase_i, bus_data_out_en_i} <= 2'h1;
      bus_data_out_i <= $urandom();
      tick(1);
      `CHK(p0_read_o, bus_data_out_i)
      @(posedge ref_clk_i);
      {bus_data_out_en_i, drv_en[0]} <= {1'b0, 8'hff};
      drv_val[0] <= 8'($urandom());
      tick(1);
      `CHK(bus_data_in_o, drv_val[0])
    end
    $display("bus mode test done");
    // programming: programmer drives all ports, then reads code back on the first port
    @(posedge ref_clk_i);
    {bus_mode_i, prog_mode_i, drv_en} <= {2'h0, 1'b1, 32'hffff_ffff};
    drv_val <= $urandom();
    tick(1);
    `CHK({p3_read_o, prog_addr_hi_o, prog_addr_lo_o, prog_code_in_o}, drv_val)
    @(posedge ref_clk_i);
    {prog_verify_i, drv_en[0]} <= {1'b1, 8'h00};
    prog_code_out_i <= $urandom();
    tick(1);
    `CHK(p0_read_o, prog_code_out_i)
    @(posedge ref_clk_i);
    {prog_mode_i, prog_verify_i, drv_en} <= '0;
    $display("programming test done");
    // reset pin one cycle short of the hold, then exactly held, with and without the lock
    for (int k = 0; k < 2; k++)
    begin
      @(posedge ref_clk_i);
      {rst_pin_i, lock2_i} <= {1'b1, k[0]};
      tick(23);
      `CHK(core_rst_o, 1'b0)
      tick(1);
      `CHK({core_rst_o, isp_active_o}, {1'b1, !k[0]})
      @(posedge ref_clk_i);
      rst_pin_i <= 1'b0;
      tick(3);
      `CHK(core_rst_o, 1'b0)
    end
    $display("reset pin test done");
    // sixty cycles hold ten latch pulses; one external data access removes one
    for (int s = 0; s < 2; s++)
    begin
      for (int i = 0; i < 20 && !ale_o; i++)
        tick(1);
      if (!ale_o)
      begin
        mismatches++;
        give_verdict();
      end
      cnt = 0;
      for (int i = 0; i < 60; i++)
      begin
        @(posedge ref_clk_i);
        ext_data_access_i <= (s == 1 && i == 0);
        #1;
        cnt += ale_o;
      end
      `CHK(cnt, 10 - s)
    end
    $display("latch pulse test done");
    give_verdict();
  end
endmodule : test_mcu_port_pin_logic
